//--- hss_sequencer.sv
// half-step stepper sequencer with apb registers
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hss_sequencer
    import hss_pkg::*;
#(
    parameter int STEP_W = 16,
    parameter int DWELL_W = 24
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // motor pins
    output logic [7:0] step_output_port,
    output logic [7:0] pin_direction_reg,
    output logic [1:0] coil_a,
    output logic [1:0] coil_b,
    output logic busy
);
    // ***************************************************************
    // declarations
    // ***************************************************************
    hss_state_t state;
    logic [STEP_W-1:0] steps_cfg;
    logic [DWELL_W-1:0] dwell_cfg;
    logic [PHASE_W-1:0] start_phase;
    logic [STEP_W-1:0] steps_remaining;
    logic [STEP_W-1:0] steps_latched;
    logic [DWELL_W-1:0] dwell_latched;
    logic [DWELL_W-1:0] dwell_cnt;
    logic [PHASE_W-1:0] phase;
    logic reverse;
    logic [PAT_W-1:0] pattern;
    hss_pins_t pins;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic start_req;
    logic dwell_done;

    // ***************************************************************
    // functions
    // ***************************************************************
    function automatic logic [PHASE_W-1:0] next_phase_of(
        input logic [PHASE_W-1:0] p,
        input logic rev
    );
        logic [PHASE_W-1:0] r;
        r = p;
        if (!rev)
        begin
            if (p == PHASE_MAX)
                r = PHASE_MIN;
            else
                r = p + 3'h1;
        end
        else
        begin
            if (p == PHASE_MIN)
                r = PHASE_MAX;
            else
                r = p - 3'h1;
        end
        return r;
    endfunction

    function automatic logic [7:0] pat_to_port(input logic [PAT_W-1:0] p);
        return {4'h0, p};
    endfunction

    // ***************************************************************
    // apb decode
    // ***************************************************************
    assign pready = 1'b1;
    assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STEPS) ||
                     (paddr == ADDR_DWELL) || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_OUT);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok && clk_en;
    assign rd_en = psel && !penable && !pwrite && clk_en;
    assign start_req = wr_en && (paddr == ADDR_CTRL) && pstrb[0] &&
                       pwdata[CTRL_START_BIT];

    // configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            steps_cfg <= STEP_W'(STEPS_DEFAULT);
            dwell_cfg <= DWELL_W'(DWELL_DEFAULT);
            start_phase <= PHASE_MIN;
        end
        else if (wr_en)
        begin
            if (paddr == ADDR_STEPS)
                steps_cfg <= pwdata[STEP_W-1:0];
            if (paddr == ADDR_DWELL)
                dwell_cfg <= pwdata[DWELL_W-1:0];
            if (paddr == ADDR_CTRL && pstrb[0] && state == HSS_IDLE)
                start_phase <= pwdata[CTRL_PHASE_MSB:CTRL_PHASE_LSB];
        end
    end

    // pin direction register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_direction_reg <= PIN_DIR_RESET;
        else if (start_req && state == HSS_IDLE)
            pin_direction_reg <= PIN_DIR_ALL_OUT;
        else if (wr_en && paddr == ADDR_CTRL && pstrb[1])
            pin_direction_reg <= pwdata[CTRL_DIR_EN_MSB:CTRL_DIR_EN_LSB];
    end

    // read data, captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= PRDATA_NONE;
        else if (rd_en)
        begin
            unique case (paddr)
                ADDR_CTRL:
                    prdata <= {16'h0000, pin_direction_reg, 1'b0,
                               start_phase, 4'h0};
                ADDR_STEPS:
                    prdata <= 32'(steps_cfg);
                ADDR_DWELL:
                    prdata <= 32'(dwell_cfg);
                ADDR_STATUS:
                    prdata <= {16'(steps_remaining), 9'h000, phase, 2'h0,
                               reverse, busy};
                ADDR_OUT:
                    prdata <= {24'h000000, step_output_port};
                default:
                    prdata <= PRDATA_NONE;
            endcase
        end
    end

    // ***************************************************************
    // pattern lookup
    // ***************************************************************
    hss_pattern_rom u_rom (
        .phase(phase),
        .pattern(pattern)
    );

    assign dwell_done = (dwell_cnt == DWELL_W'(1)) ||
                        (dwell_cnt == '0);

    // ***************************************************************
    // sequencer state
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= HSS_IDLE;
        else if (clk_en)
        begin
            unique case (state)
                HSS_IDLE:
                    if (start_req)
                        state <= HSS_CLEAR;
                HSS_CLEAR:
                    state <= HSS_INIT_DWELL;
                HSS_INIT_DWELL:
                    if (dwell_done)
                        state <= (steps_latched == '0) ? HSS_IDLE
                                                       : HSS_APPLY;
                HSS_APPLY:
                    state <= HSS_DWELL;
                HSS_DWELL:
                    if (dwell_done)
                    begin
                        if (steps_remaining != '0)
                            state <= HSS_APPLY;
                        else if (!reverse)
                            state <= HSS_APPLY;
                        else
                            state <= HSS_IDLE;
                    end
            endcase
        end
    end

    // move parameters sampled at request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            steps_latched <= '0;
            dwell_latched <= '0;
        end
        else if (clk_en && state == HSS_IDLE && start_req)
        begin
            steps_latched <= steps_cfg;
            dwell_latched <= dwell_cfg;
        end
    end

    // dwell counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dwell_cnt <= '0;
        else if (clk_en)
        begin
            if (state == HSS_CLEAR || state == HSS_APPLY)
                dwell_cnt <= dwell_latched;
            else if (dwell_cnt != '0)
                dwell_cnt <= dwell_cnt - DWELL_W'(1);
        end
    end

    // phase, direction and remaining count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= PHASE_MIN;
            reverse <= 1'b0;
            steps_remaining <= '0;
        end
        else if (clk_en)
        begin
            unique case (state)
                HSS_IDLE:
                    if (start_req)
                    begin
                        phase <= pwdata[CTRL_PHASE_MSB:CTRL_PHASE_LSB];
                        reverse <= 1'b0;
                    end
                HSS_INIT_DWELL:
                    if (dwell_done)
                        steps_remaining <= steps_latched;
                HSS_APPLY:
                    steps_remaining <= steps_remaining - STEP_W'(1);
                HSS_DWELL:
                    if (dwell_done)
                    begin
                        if (steps_remaining == '0 && !reverse)
                        begin
                            reverse <= 1'b1;
                            steps_remaining <= steps_latched;
                            phase <= next_phase_of(phase, 1'b1);
                        end
                        else if (steps_remaining != '0)
                            phase <= next_phase_of(phase, reverse);
                    end
                default:
                    ;
            endcase
        end
    end

    // output port register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            step_output_port <= PORT_RESET;
        else if (clk_en)
        begin
            if (state == HSS_IDLE && start_req)
                step_output_port <= PORT_RESET;
            else if (state == HSS_CLEAR || state == HSS_APPLY)
                step_output_port <= pat_to_port(pattern);
        end
    end

    assign pins = '{port: step_output_port, dir: pin_direction_reg};
    assign coil_b = pins.port[3:2];
    assign coil_a = pins.port[1:0];
    assign busy = (state != HSS_IDLE);
endmodule
`default_nettype wire

//--- hss_pkg.sv
// package: constants and carriers for the half-step stepper sequencer
package hss_pkg;
    // ***************************************************************
    // register map (byte addresses)
    // ***************************************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STEPS = 12'h004;
    localparam logic [11:0] ADDR_DWELL = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;
    localparam logic [11:0] ADDR_OUT = 12'h010;
    // ctrl fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_PHASE_LSB = 4;
    localparam int CTRL_PHASE_MSB = 6;
    localparam int CTRL_DIR_EN_LSB = 8;
    localparam int CTRL_DIR_EN_MSB = 15;
    // status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REV_BIT = 1;
    localparam int STAT_PHASE_LSB = 4;
    localparam int STAT_PHASE_MSB = 6;
    // ***************************************************************
    // sequence constants
    // ***************************************************************
    localparam int SEQUENCE_LENGTH = 8;
    localparam int PHASE_W = 3;
    localparam int PAT_W = 4;
    localparam logic [PHASE_W-1:0] PHASE_MAX = 3'h7;
    localparam logic [PHASE_W-1:0] PHASE_MIN = 3'h0;
    localparam int STEPS_DEFAULT = 100;
    localparam int DWELL_DEFAULT = 2000;
    localparam logic [7:0] PIN_DIR_RESET = 8'h00;
    localparam logic [7:0] PIN_DIR_ALL_OUT = 8'hFF;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [31:0] PRDATA_NONE = 32'h0000_0000;
    // ***************************************************************
    // types
    // ***************************************************************
    typedef enum logic [2:0] {
        HSS_IDLE,
        HSS_CLEAR,
        HSS_INIT_DWELL,
        HSS_APPLY,
        HSS_DWELL
    } hss_state_t;
    typedef struct packed {
        logic [7:0] port;
        logic [7:0] dir;
    } hss_pins_t;
endpackage

//--- hss_pattern_rom.sv
// pattern table: phase index to coil-drive nibble
`timescale 1ns/1ps
`default_nettype none
module hss_pattern_rom
    import hss_pkg::*;
(
    // lookup
    input wire logic [PHASE_W-1:0] phase,
    output logic [PAT_W-1:0] pattern
);
    always_comb
    begin
        unique case (phase)
            3'h0: pattern = 4'h6;
            3'h1: pattern = 4'h2;
            3'h2: pattern = 4'hA;
            3'h3: pattern = 4'h8;
            3'h4: pattern = 4'h9;
            3'h5: pattern = 4'h1;
            3'h6: pattern = 4'h5;
            3'h7: pattern = 4'h4;
        endcase
    end
endmodule
`default_nettype wire

//--- hss_sequencer_sva.sv
// checker: port assertions for the stepper sequencer
`timescale 1ns/1ps
`default_nettype none
module hss_sequencer_sva
    import hss_pkg::*;
(
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // motor pins
    input wire logic [7:0] step_output_port,
    input wire logic [7:0] pin_direction_reg,
    input wire logic [1:0] coil_a,
    input wire logic [1:0] coil_b,
    input wire logic busy
);
    logic start_w;
    logic [3:0] pn;
    function automatic logic [3:0] pat(input logic [2:0] i);
        logic [31:0] t;
        t = 32'h4519_8A26;
        return t[i*4 +: 4];
    endfunction
    function automatic logic adj(input logic [3:0] a, input logic [3:0] b);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (pat(3'(i)) == a && (pat(3'(i+1)) == b || pat(3'(i+7)) == b))
                r = 1'b1;
        end
        return r;
    endfunction
    assign pn = step_output_port[3:0];
    assign start_w = psel && penable && pwrite && clk_en && pwdata[0]
        && pstrb[0] && paddr == ADDR_CTRL;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_UPPER: assert property (step_output_port[7:4] == 4'h0)
        else $error("upper port bits set");
    AST_COIL: assert property (coil_b == pn[3:2] && coil_a == pn[1:0])
        else $error("coil pins differ from port");
    AST_LEGAL: assert property (pn inside {4'h0, 4'h6, 4'h2, 4'hA,
        4'h8, 4'h9, 4'h1, 4'h5, 4'h4})
        else $error("pattern not in table");
    AST_CLEAR: assert property (start_w && !busy |=> busy && pn == 4'h0)
        else $error("start did not clear port");
    AST_FIRST: assert property (start_w && !busy |-> ##2
        pn == pat($past(pwdata[6:4], 2)))
        else $error("start pattern wrong");
    AST_ADJ: assert property ($changed(pn) && $past(pn) != 4'h0
        && pn != 4'h0 |-> adj($past(pn), pn))
        else $error("step skipped a phase");
    AST_IDLE: assert property (!busy && !start_w |=> $stable(pn))
        else $error("port moved while idle");
    AST_FREEZE: assert property (!clk_en |=> $stable(pn) && $stable(busy))
        else $error("state moved while frozen");
    AST_ERR: assert property (psel && penable
        && !(paddr inside {[12'h000:12'h010]}) |-> pslverr && pready)
        else $error("unmapped access not refused");
endmodule
bind hss_sequencer hss_sequencer_sva u_sva (.*);
`default_nettype wire

//--- hss_motor_model.sv
// partner: two-coil motor counting half-steps from the coil drive
`timescale 1ns/1ps
`default_nettype none
module hss_motor_model
(
    // coil terminals
    input wire logic pclk,
    input wire logic [1:0] coil_a,
    input wire logic [1:0] coil_b,
    // observed motion
    output logic [7:0] n_fwd,
    output logic [7:0] n_rev,
    output logic err
);
    logic [3:0] now_p;
    logic [3:0] last;
    function automatic int idx(input logic [3:0] p);
        logic [31:0] t;
        t = 32'h4519_8A26;
        idx = -1;
        for (int i = 0; i < 8; i++)
            if (t[i*4 +: 4] == p)
                idx = i;
    endfunction
    assign now_p = {coil_b, coil_a};
    always @(posedge pclk)
    begin
        last <= now_p;
        if (now_p == 4'h0)
        begin
            n_fwd <= 8'h00;
            n_rev <= 8'h00;
            err <= 1'b0;
        end
        else if (idx(now_p) < 0)
            err <= 1'b1;
        else if (last != 4'h0 && now_p != last)
        begin
            case ((idx(now_p) - idx(last) + 8) % 8)
                1:
                begin
                    n_fwd <= n_fwd + 8'h01;
                    if (n_rev != 8'h00)
                        err <= 1'b1;
                end
                7: n_rev <= n_rev + 8'h01;
                default: err <= 1'b1;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- tb_top.sv
// testbench: random and corner moves of the stepper sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hss_pkg::*;
;
    logic pclk, presetn, clk_en, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, lfsr, rd;
    logic [3:0] pstrb, first;
    logic pready, pslverr, busy, err, rerr;
    logic [7:0] step_output_port, pin_direction_reg, n_fwd, n_rev, prev;
    logic [1:0] coil_a, coil_b;
    int failures, cmp_count, hold, min_hold;
    hss_sequencer DUT (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .step_output_port(step_output_port),
        .pin_direction_reg(pin_direction_reg),
        .coil_a(coil_a),
        .coil_b(coil_b),
        .busy(busy)
    );
    hss_motor_model u_motor (
        .pclk(pclk),
        .coil_a(coil_a),
        .coil_b(coil_b),
        .n_fwd(n_fwd),
        .n_rev(n_rev),
        .err(err)
    );
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    function automatic logic [3:0] pat(input logic [2:0] i);
        logic [31:0] t;
        t = 32'h4519_8A26;
        return t[i*4 +: 4];
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // idle status after a move: one phase behind start, reverse set
    function automatic logic [31:0] exp_status(input logic [2:0] ph);
        return {25'h0, ph - 3'h1, 4'h2};
    endfunction
    function automatic logic [31:0] exp_ctrl(input logic [2:0] ph);
        return {16'h0000, PIN_DIR_ALL_OUT, 1'b0, ph, 4'h0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input int d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++n < 50);
        if (n >= 50)
        begin
            failures++;
            final_report();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic move(input logic [2:0] ph, input int n, input int d);
        int c;
        apb(ADDR_STEPS, 1'b1, n);
        apb(ADDR_DWELL, 1'b1, d);
        apb(ADDR_CTRL, 1'b1, {ph, 4'h1});
        chk(pin_direction_reg, PIN_DIR_ALL_OUT);
        apb(ADDR_CTRL, 1'b1, {8'hFF, 1'b0, ph + 3'h3, 4'h1});
        apb(ADDR_STATUS, 1'b0, 0);
        chk(rd[0], 1'b1);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
        c = 0;
        while (busy !== 1'b0 && c < 2000)
        begin
            @(posedge pclk);
            c++;
        end
        if (c >= 2000)
        begin
            failures++;
            final_report();
        end
        chk(first, pat(ph));
        chk(n_fwd == n || n_fwd == n - 1, 1'b1);
        chk(n_rev, n);
        chk(err, 1'b0);
        chk(min_hold >= d, 1'b1);
        apb(ADDR_STATUS, 1'b0, 0);
        chk(rd, exp_status(ph));
        apb(ADDR_CTRL, 1'b0, 0);
        chk(rd, exp_ctrl(ph));
        $display("move phase %0d steps %0d dwell %0d done", ph, n, d);
    endtask
    // coil monitor: first pattern and shortest hold
    always @(posedge pclk)
    begin
        prev <= step_output_port;
        if (step_output_port == 8'h00)
        begin
            first <= 4'h0;
            min_hold <= 99999;
            hold <= 0;
        end
        else if (step_output_port == prev)
            hold <= hold + 1;
        else
        begin
            if (first == 4'h0)
                first <= step_output_port[3:0];
            if (prev != 8'h00 && hold < min_hold)
                min_hold <= hold;
            hold <= 1;
        end
    end
    task automatic final_report();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        presetn = 1'b0;
        clk_en = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        lfsr = 32'hE1D7546D;
        failures = 0;
        cmp_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pin_direction_reg, PIN_DIR_RESET);
        chk(step_output_port, PORT_RESET);
        apb(ADDR_STEPS, 1'b0, 0);
        chk(rd, STEPS_DEFAULT);
        apb(ADDR_DWELL, 1'b0, 0);
        chk(rd, DWELL_DEFAULT);
        apb(12'h014, 1'b0, 0);
        chk(rerr, 1'b1);
        chk(rd, PRDATA_NONE);
        $display("reset and register checks done");
        move(3'h6, 3, 4);
        move(3'h0, 1, 2);
        repeat (6)
        begin
            lfsr = lfsr_next(lfsr);
            move(lfsr[2:0], 2 + lfsr[4:3], 2 + lfsr[7:5]);
        end
        final_report();
    end
    // watchdog far beyond the expected run
    initial
    begin
        #100000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
